// [sim/stc_core_monitor.sv]
// checker for the timer core: bus handshakes, refusals and request outputs
// assumes one clock domain with a synchronous active-low reset; bound onto stc_core
`timescale 1ns/1ns
`include "stc_defs.svh"
module stc_core_monitor #(
  parameter int NCH = 6
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic wait_mode_in,
  input wire logic stop_mode_in,
  input wire logic break_in,
  input wire logic ext_clk_force_input_out,
  input wire logic [NCH-1:0] ch_pin_oe_out,
  input wire logic ovf_irq_out,
  input wire logic [NCH-1:0] ch_irq_out,
  input wire logic wake_req_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // a register write may legally change requests, so it is excluded
  logic wr_q;
  always_ff @(posedge clock_in) wr_q <= s_axi_wvalid_in && s_axi_wready_out;
  property p_wake;
    wake_req_out == (ovf_irq_out || (|ch_irq_out));
  endproperty
  a_wake: assert property (p_wake) else $error("wake request mismatch");
  property p_wait_rd;
    s_axi_arvalid_in && s_axi_arready_out && wait_mode_in |=>
      s_axi_rvalid_out && s_axi_rresp_out == `STC_RESP_SLVERR && s_axi_rdata_out == 32'h0;
  endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("wait read not refused");
  property p_rd_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_stand;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
  property p_b_stand;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
  property p_one_rd;
    s_axi_rvalid_out |-> !s_axi_arready_out && (s_axi_rresp_out == `STC_RESP_OKAY ||
      (s_axi_rresp_out == `STC_RESP_SLVERR && s_axi_rdata_out == 32'h0));
  endproperty
  a_one_rd: assert property (p_one_rd) else $error("second read accepted");
  property p_force;
    $changed(ext_clk_force_input_out) |-> s_axi_bvalid_out || wr_q;
  endproperty
  a_force: assert property (p_force) else $error("pin direction changed unasked");
  property p_halt;
    $rose(wake_req_out) && !s_axi_bvalid_out && !wr_q |->
      !$past(break_in) && !$past(stop_mode_in);
  endproperty
  a_halt: assert property (p_halt) else $error("request rose while halted");
  property p_rst;
    disable iff (1'b0) !resetn_in |=> !s_axi_bvalid_out && !s_axi_rvalid_out
      && !wake_req_out && ch_pin_oe_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_ovf: cover property ($rose(ovf_irq_out));
  c_ch: cover property ($rose(ch_irq_out[0]));
  c_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == `STC_RESP_SLVERR);
endmodule

bind stc_core stc_core_monitor #(.NCH(NCH)) u_mon (
  .clock_in, .resetn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .wait_mode_in, .stop_mode_in, .break_in,
  .ext_clk_force_input_out, .ch_pin_oe_out, .ovf_irq_out, .ch_irq_out, .wake_req_out
);

// [sim/stc_host_model.sv]
// register bus master standing in for the processor core
// assumes the bench calls wr and rd one at a time, just after a rising edge
`timescale 1ns/1ns
module stc_host_model (
  input wire logic clock_in,
  output logic [9:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [9:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // cycles the master lags before taking an answer; slave must hold it
  int lag = 0;
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end
  task automatic wr(input logic [7:0] i, input logic [15:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clock_in);
    awaddr_out <= {i, 2'b00};
    awvalid_out <= 1'b1;
    wdata_out <= {16'h0, d};
    wstrb_out <= 4'h3;
    wvalid_out <= 1'b1;
    forever begin
      @(posedge clock_in);
      if (bvalid_in && bready_out) break;
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
      if (k++ >= lag) bready_out <= 1'b1;
    end
    r = bresp_in;
    bready_out <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clock_in);
    araddr_out <= {i, 2'b00};
    arvalid_out <= 1'b1;
    forever begin
      @(posedge clock_in);
      if (rvalid_in && rready_out) break;
      if (arready_in) arvalid_out <= 1'b0;
      if (k++ >= lag) rready_out <= 1'b1;
    end
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// [sim/tb_top.sv]
// self-checking bench for the six-channel timer core
// assumes core, checker and host model compiled before it
`timescale 1ns/1ns
module tb_top;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [9:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in, ovf_irq_out, wake_req_out;
  logic ext_clk_force_input_out;
  logic wait_mode_in = 0, stop_mode_in = 0, break_in = 0, break_clear_enable_in = 0;
  logic external_timer_clock_pin_in = 0;
  logic [5:0] ch_pin_in, ch_pin_out, ch_pin_oe_out, ch_irq_out;
  logic [5:0] pin_drv = 6'h0;
  int errors = 0;
  int n_tests = 0;
  always #25 clock_in = ~clock_in;
  assign ch_pin_in = (ch_pin_oe_out & ch_pin_out) | (~ch_pin_oe_out & pin_drv);
  // idle channels see noise; it must not disturb anything
  always @(posedge clock_in) pin_drv[5:3] <= 3'($urandom);
  stc_core u_dut (.clock_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .wait_mode_in, .stop_mode_in,
    .break_in, .break_clear_enable_in, .external_timer_clock_pin_in,
    .ext_clk_force_input_out, .ch_pin_in, .ch_pin_out, .ch_pin_oe_out, .ovf_irq_out,
    .ch_irq_out, .wake_req_out);
  stc_host_model u_host (.clock_in, .awaddr_out(s_axi_awaddr_in),
    .awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out),
    .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in), .wvalid_out(s_axi_wvalid_in),
    .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out), .bvalid_in(s_axi_bvalid_out),
    .bready_out(s_axi_bready_in), .araddr_out(s_axi_araddr_in),
    .arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out),
    .rdata_in(s_axi_rdata_out), .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out),
    .rready_out(s_axi_rready_in));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic w(input logic [7:0] i, input logic [15:0] d);
    u_host.wr(i, d, rs);
  endtask
  task automatic rd(input logic [7:0] i);
    u_host.rd(i, rv, rs);
  endtask
  task automatic cnt(output logic [15:0] c);
    rd(8'h22);
    c[15:8] = rv[7:0];
    rd(8'h23);
    c[7:0] = rv[7:0];
  endtask
  // one count of slack: edge alignment of start and stop is not fixed
  function automatic bit near(input logic [15:0] a, input int e);
    return int'(a) >= e - 1 && int'(a) <= e + 1;
  endfunction
  task automatic till_ovf;
    for (int i = 0; i < 40 && ovf_irq_out !== 1'b1; i++) run(1);
  endtask
  initial begin
    run(60000);
    errors++;
    test_done();
  end
  initial begin
    logic [15:0] a, b, r0, r1;
    logic [7:0] h;
    int d;
    void'($urandom(32'hcd5f));
    run(16);
    resetn_in <= 1'b1;
    u_host.lag = 2;
    rd(8'h20);
    chk("status", rv, 32'h20);
    cnt(a);
    chk("cnt_reset", a, 16'h0);
    rd(8'h3f);
    chk("unmapped", rs, 2'h2);
    w(8'h22, 16'h55);
    cnt(a);
    chk("cnt_ro", a, 16'h0);
    u_host.lag = 0;
    for (int p = 0; p < 7; p++) begin
      d = 200 + $urandom % 500;
      w(8'h20, 16'h30 | p);
      cnt(a);
      chk("stop_reset", a, 16'h0);
      w(8'h20, p);
      run(d);
      w(8'h20, 16'h20 | p);
      cnt(a);
      chk("divide", near(a, (d + 3) >> p), 1);
    end
    w(8'h20, 16'h0);
    for (int k = 0; k < 3; k++) begin
      cnt(r0);
      {wait_mode_in, stop_mode_in, break_in} <= 3'b001 << k;
      run(2);
      cnt(a);
      if (k == 2) w(8'h20, 16'h20);
      run(100);
      cnt(b);
      if (k < 2) chk("halted", b, a);
      else chk("wait_refused", rs, 2'h2);
      {wait_mode_in, stop_mode_in, break_in} <= 3'b0;
      run(100);
      cnt(r1);
      chk("runs", 16'(r1 - r0) > 16'd160, k == 2);
    end
    w(8'h20, 16'h10);
    w(8'h20, 16'h20);
    cnt(a);
    chk("trst", near(a, 3), 1);
    rd(8'h20);
    chk("trst_zero", rv, 32'h20);
    w(8'h20, 16'h0);
    rd(8'h22);
    h = rv[7:0];
    run(300);
    rd(8'h22);
    rd(8'h23);
    a = {h, rv[7:0]};
    cnt(b);
    chk("latch", near(16'(b - a), 309), 1);
    w(8'h20, 16'h30);
    w(8'h25, 16'h10);
    w(8'h24, 16'h0);
    w(8'h20, 16'h40);
    run(60);
    chk("ovf_held_off", ovf_irq_out, 1'b0);
    w(8'h25, 16'h10);
    till_ovf();
    chk("ovf", ovf_irq_out, 1'b1);
    rd(8'h20);
    run(20);
    w(8'h20, 16'h40);
    rd(8'h20);
    chk("ovf_race", rv[7], 1'b1);
    w(8'h20, 16'he0);
    w(8'h20, 16'h20);
    chk("irq_masked", ovf_irq_out, 1'b0);
    w(8'h20, 16'h60);
    chk("one_ignored", ovf_irq_out, 1'b1);
    for (int c = 0; c < 2; c++) begin
      rd(8'h20);
      break_clear_enable_in <= c[0];
      break_in <= 1'b1;
      w(8'h20, 16'h60);
      chk("brk_clear", ovf_irq_out, !c[0]);
      break_in <= 1'b0;
      break_clear_enable_in <= 1'b0;
      w(8'h20, 16'h60);
      chk("after_brk", ovf_irq_out, 1'b0);
      w(8'h20, 16'h40);
      till_ovf();
      w(8'h20, 16'h60);
    end
    w(8'h20, 16'h30);
    w(8'h30, 16'h8);
    w(8'h26, 16'h5c);
    w(8'h27, 16'h44);
    w(8'h28, 16'h19);
    pin_drv[1] <= 1'b1;
    run(8);
    chk("cap_stopped", ch_irq_out[1], 1'b0);
    pin_drv[1] <= 1'b0;
    w(8'h20, 16'h0);
    run(40);
    chk("pin_dir", ch_pin_oe_out[2:0], 3'b101);
    chk("compare", {ch_irq_out[0], ch_pin_out[0]}, 2'b11);
    for (int i = 0; i < 40; i++) begin
      run(1);
      chk("max_duty", ch_pin_out[2], 1'b1);
    end
    pin_drv[1] <= 1'b1;
    run(8);
    chk("capture", ch_irq_out[1], 1'b1);
    rd(8'h27);
    w(8'h27, 16'h44);
    chk("ch_clear", ch_irq_out[1], 1'b0);
    d = 4 + $urandom % 10;
    w(8'h20, 16'h37);
    chk("pin_input", ext_clk_force_input_out, 1'b1);
    w(8'h20, 16'h07);
    repeat (d) begin
      external_timer_clock_pin_in <= 1'b1;
      run(4);
      external_timer_clock_pin_in <= 1'b0;
      run(4);
    end
    run(8);
    w(8'h20, 16'h27);
    cnt(a);
    chk("ext_count", a, 16'(d));
    w(8'h20, 16'h20);
    chk("pin_free", ext_clk_force_input_out, 1'b0);
    test_done();
  end
endmodule

// [src/stc_core.sv]
// six-channel 16-bit timer counter core with an AXI4-Lite register slave
// assumes all inputs but external_timer_clock_pin_in synchronous to clock_in; low-power and break states come from the system
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "stc_defs.svh"

module stc_core import stc_pkg::*; #(
  parameter int NCH = 6
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [9:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [9:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic wait_mode_in,
  input wire logic stop_mode_in,
  input wire logic break_in,
  input wire logic break_clear_enable_in,
  input wire logic external_timer_clock_pin_in,
  output logic ext_clk_force_input_out,
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe_out,
  output logic ovf_irq_out,
  output logic [NCH-1:0] ch_irq_out,
  output logic wake_req_out
);

  if (NCH < 1 || NCH > 8) begin : g_check
    $error("stc_core: NCH must be 1 to 8");
  end

  function automatic logic idx_mapped(input logic [7:0] idx);
    logic hit;
    hit = (idx == `STC_IDX_STATUS) || (idx == `STC_IDX_CNT_H) || (idx == `STC_IDX_CNT_L) ||
          (idx == `STC_IDX_MOD_H) || (idx == `STC_IDX_MOD_L);
    for (int k = 0; k < NCH; k++) begin
      if (idx == `STC_IDX_CHCTL_BASE + 8'(k) || idx == `STC_IDX_CHVAL_BASE + 8'(k)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic ps_tick(input logic [5:0] div, input logic [2:0] ps);
    logic t;
    unique case (ps)
      3'h0: t = 1'b1;
      3'h1: t = div[0];
      3'h2: t = &div[1:0];
      3'h3: t = &div[2:0];
      3'h4: t = &div[3:0];
      3'h5: t = &div[4:0];
      3'h6: t = &div[5:0];
      3'h7: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic stc_ch_mode_t ch_mode(input logic [6:0] ctl);
    stc_ch_mode_t m;
    if (ctl[`STC_ELSB_BIT:`STC_ELSA_BIT] == 2'h0) begin
      m = STC_CH_IDLE;
    end else if (ctl[`STC_MSB_BIT] || ctl[`STC_MSA_BIT]) begin
      m = STC_CH_COMPARE;
    end else begin
      m = STC_CH_CAPTURE;
    end
    return m;
  endfunction

  // bus slave state
  logic aw_full_q;
  logic [7:0] aw_idx_q;
  logic w_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_d;
  logic [7:0] ar_idx;
  logic wr_go;
  logic rd_go;
  logic wr_en;
  logic rd_en;
  logic protect;

  // timer state
  logic overflow_interrupt_enable_q;
  logic counter_stop_bit_q;
  logic [2:0] ps_q;
  logic tof_q;
  logic tof_arm_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic mod_inhibit_q;
  logic [5:0] div_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic latch_q;
  logic [7:0] lowbuf_q;
  logic running;
  logic tick;
  logic at_mod;
  logic ovf_event;
  logic cnt_rst;
  logic status_wr;
  logic tof_clear;
  logic [NCH-1:0] chf;
  logic [NCH-1:0] chie;
  logic [7:0] chctl_rd [NCH];
  logic [15:0] chval_rd [NCH];

  assign ar_idx = s_axi_araddr_in[9:2];
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go = s_axi_arvalid_in && !rvalid_q;
  // no access while the processor waits; such cycles end in an error answer
  assign wr_en = wr_go && !wait_mode_in && idx_mapped(aw_idx_q);
  assign rd_en = rd_go && !wait_mode_in && idx_mapped(ar_idx);
  assign protect = break_in && !break_clear_enable_in;

  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out = !w_full_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      aw_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
    end else if (s_axi_awvalid_in && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr_in[9:2];
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid_in && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `STC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_en ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ar_idx == `STC_IDX_STATUS) begin
      rdata_d[`STC_TOF_BIT] = tof_q;
      rdata_d[`STC_OVERFLOW_INTERRUPT_ENABLE_BIT] = overflow_interrupt_enable_q;
      rdata_d[`STC_COUNTER_STOP_BIT_BIT] = counter_stop_bit_q;
      rdata_d[`STC_PS_MSB:`STC_PS_LSB] = ps_q;
    end else if (ar_idx == `STC_IDX_CNT_H) begin
      rdata_d[7:0] = cnt_q[15:8];
    end else if (ar_idx == `STC_IDX_CNT_L) begin
      rdata_d[7:0] = latch_q ? lowbuf_q : cnt_q[7:0];
    end else if (ar_idx == `STC_IDX_MOD_H) begin
      rdata_d[7:0] = mod_q[15:8];
    end else if (ar_idx == `STC_IDX_MOD_L) begin
      rdata_d[7:0] = mod_q[7:0];
    end
    for (int k = 0; k < NCH; k++) begin
      if (ar_idx == `STC_IDX_CHCTL_BASE + 8'(k)) begin
        rdata_d[7:0] = chctl_rd[k];
      end
      if (ar_idx == `STC_IDX_CHVAL_BASE + 8'(k)) begin
        rdata_d[15:0] = chval_rd[k];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `STC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_en ? rdata_d : 32'h0000_0000;
      rresp_q <= rd_en ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // status and control
  assign status_wr = wr_en && aw_idx_q == `STC_IDX_STATUS && wstrb_q[0];
  assign cnt_rst = status_wr && wdata_q[`STC_TRST_BIT];
  assign tof_clear = status_wr && !wdata_q[`STC_TOF_BIT] && tof_arm_q && !protect;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      overflow_interrupt_enable_q <= `STC_OVERFLOW_INTERRUPT_ENABLE_RESET;
      counter_stop_bit_q <= `STC_COUNTER_STOP_BIT_RESET;
      ps_q <= `STC_PS_RESET;
    end else if (status_wr) begin
      overflow_interrupt_enable_q <= wdata_q[`STC_OVERFLOW_INTERRUPT_ENABLE_BIT];
      counter_stop_bit_q <= wdata_q[`STC_COUNTER_STOP_BIT_BIT];
      ps_q <= wdata_q[`STC_PS_MSB:`STC_PS_LSB];
    end
  end

  // set beats clear, and any new overflow drops a half-done clear
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tof_q <= 1'b0;
    end else if (ovf_event) begin
      tof_q <= 1'b1;
    end else if (tof_clear) begin
      tof_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tof_arm_q <= 1'b0;
    end else if (ovf_event) begin
      tof_arm_q <= 1'b0;
    end else if (protect) begin
      tof_arm_q <= tof_arm_q;
    end else if (rd_en && ar_idx == `STC_IDX_STATUS && tof_q) begin
      tof_arm_q <= 1'b1;
    end else if (status_wr) begin
      tof_arm_q <= 1'b0;
    end
  end

  assign ovf_irq_out = tof_q && overflow_interrupt_enable_q;
  assign wake_req_out = ovf_irq_out || (|ch_irq_out);

  // clock source
  assign ext_clk_force_input_out = ps_q == `STC_PS_EXT;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_timer_clock_pin_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // wait mode keeps counting; stop mode, break and the stop bit freeze it
  assign running = !counter_stop_bit_q && !stop_mode_in && !break_in;
  assign tick = running && (ps_q == `STC_PS_EXT ? (ext_s2_q && !ext_s3_q) :
                ps_tick(div_q, ps_q));
  assign at_mod = cnt_q == mod_q;
  assign ovf_event = tick && at_mod && !mod_inhibit_q;

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      div_q <= 6'h00;
    end else if (cnt_rst) begin
      div_q <= 6'h00;
    end else if (running) begin
      div_q <= div_q + 6'h01;
    end
  end

  // reset-bit wins over ticking, so stop plus reset parks at zero
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt_q <= 16'h0000;
    end else if (cnt_rst) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= at_mod ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mod_q <= `STC_MOD_RESET;
      mod_inhibit_q <= 1'b0;
    end else if (wr_en && wstrb_q[0] && aw_idx_q == `STC_IDX_MOD_H) begin
      mod_q[15:8] <= wdata_q[7:0];
      mod_inhibit_q <= 1'b1;
    end else if (wr_en && wstrb_q[0] && aw_idx_q == `STC_IDX_MOD_L) begin
      mod_q[7:0] <= wdata_q[7:0];
      mod_inhibit_q <= 1'b0;
    end
  end

  // latch survives a break on purpose; software must read the low byte
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      latch_q <= 1'b0;
      lowbuf_q <= 8'h00;
    end else if (cnt_rst) begin
      latch_q <= 1'b0;
      lowbuf_q <= 8'h00;
    end else if (rd_en && ar_idx == `STC_IDX_CNT_H && !latch_q) begin
      latch_q <= 1'b1;
      lowbuf_q <= cnt_q[7:0];
    end else if (rd_en && ar_idx == `STC_IDX_CNT_L) begin
      latch_q <= 1'b0;
    end
  end

  // channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [6:0] ctl_q;
    logic [15:0] val_q;
    logic f_q;
    logic arm_q;
    logic pin_q;
    logic out_q;
    logic ev;
    logic cap;
    logic cmp;
    logic ctl_wr;
    logic f_clear;
    logic edge_hit;
    stc_ch_mode_t mode;
    stc_edge_t edge_sel;

    assign mode = ch_mode(ctl_q);
    assign edge_sel = stc_edge_t'(ctl_q[`STC_ELSB_BIT:`STC_ELSA_BIT]);
    assign ctl_wr = wr_en && wstrb_q[0] && aw_idx_q == `STC_IDX_CHCTL_BASE + 8'(i);
    assign f_clear = ctl_wr && !wdata_q[`STC_CHF_BIT] && arm_q && !protect;

    always_comb begin
      edge_hit = 1'b0;
      unique case (edge_sel)
        STC_EDGE_NONE: edge_hit = 1'b0;
        STC_EDGE_RISE: edge_hit = ch_pin_in[i] && !pin_q;
        STC_EDGE_FALL: edge_hit = !ch_pin_in[i] && pin_q;
        STC_EDGE_ANY: edge_hit = ch_pin_in[i] != pin_q;
      endcase
    end

    // captures need a live timer: no stop bit, no break, no stop mode
    assign cap = mode == STC_CH_CAPTURE && edge_hit && !counter_stop_bit_q && !break_in &&
                 !stop_mode_in;
    assign cmp = mode == STC_CH_COMPARE && tick && cnt_q == val_q;
    assign ev = cap || cmp;

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        pin_q <= 1'b0;
      end else begin
        pin_q <= ch_pin_in[i];
      end
    end

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        ctl_q <= `STC_CHCTL_RESET;
      end else if (ctl_wr) begin
        ctl_q <= wdata_q[6:0];
      end
    end

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        val_q <= `STC_CHVAL_RESET;
      end else if (cap) begin
        val_q <= cnt_q;
      end else if (wr_en && aw_idx_q == `STC_IDX_CHVAL_BASE + 8'(i)) begin
        if (wstrb_q[1]) begin
          val_q[15:8] <= wdata_q[15:8];
        end
        if (wstrb_q[0]) begin
          val_q[7:0] <= wdata_q[7:0];
        end
      end
    end

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        f_q <= 1'b0;
      end else if (ev) begin
        f_q <= 1'b1;
      end else if (f_clear) begin
        f_q <= 1'b0;
      end
    end

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        arm_q <= 1'b0;
      end else if (ev) begin
        arm_q <= 1'b0;
      end else if (protect) begin
        arm_q <= arm_q;
      end else if (rd_en && ar_idx == `STC_IDX_CHCTL_BASE + 8'(i) && f_q) begin
        arm_q <= 1'b1;
      end else if (ctl_wr) begin
        arm_q <= 1'b0;
      end
    end

    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        out_q <= 1'b1;
      end else if (mode != STC_CH_COMPARE) begin
        out_q <= !ctl_q[`STC_MSA_BIT];
      end else if (cmp) begin
        unique case (edge_sel)
          STC_EDGE_RISE: out_q <= !out_q;
          STC_EDGE_FALL: out_q <= 1'b0;
          STC_EDGE_ANY: out_q <= 1'b1;
          default: out_q <= out_q;
        endcase
      end else if (tick && at_mod && ctl_q[`STC_TOV_BIT]) begin
        out_q <= !out_q;
      end
    end

    assign ch_pin_out[i] = (ctl_q[`STC_MAX_BIT] && !ctl_q[`STC_TOV_BIT]) ? 1'b1 : out_q;
    assign ch_pin_oe_out[i] = mode == STC_CH_COMPARE;
    assign chf[i] = f_q;
    // flag sits above ctl_q, so the enable keeps its register position here
    assign chie[i] = ctl_q[`STC_CHIE_BIT];
    assign chctl_rd[i] = {f_q, ctl_q};
    assign chval_rd[i] = val_q;
  end

  assign ch_irq_out = chf & chie;

endmodule

// [src/stc_defs.svh]
// register indices, field positions, reset values and bus codes of the timer core
// assumes a 32-bit register bus, one aligned word per index (byte address = 4 * index)
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

`define STC_IDX_STATUS 8'h20
`define STC_IDX_CNT_H 8'h22
`define STC_IDX_CNT_L 8'h23
`define STC_IDX_MOD_H 8'h24
`define STC_IDX_MOD_L 8'h25
`define STC_IDX_CHCTL_BASE 8'h26
`define STC_IDX_CHVAL_BASE 8'h30

`define STC_TOF_BIT 7
`define STC_OVERFLOW_INTERRUPT_ENABLE_BIT 6
`define STC_COUNTER_STOP_BIT_BIT 5
`define STC_TRST_BIT 4
`define STC_PS_MSB 2
`define STC_PS_LSB 0
`define STC_PS_EXT 3'h7

`define STC_CHF_BIT 7
`define STC_CHIE_BIT 6
`define STC_MSB_BIT 5
`define STC_MSA_BIT 4
`define STC_ELSB_BIT 3
`define STC_ELSA_BIT 2
`define STC_TOV_BIT 1
`define STC_MAX_BIT 0

`define STC_OVERFLOW_INTERRUPT_ENABLE_RESET 1'h0
`define STC_COUNTER_STOP_BIT_RESET 1'h1
`define STC_PS_RESET 3'h0
`define STC_MOD_RESET 16'hffff
`define STC_CHCTL_RESET 7'h00
`define STC_CHVAL_RESET 16'h0000

`define STC_RESP_OKAY 2'h0
`define STC_RESP_SLVERR 2'h2

`endif

// [src/stc_pkg.sv]
// types shared by the timer core
// assumes the constants header is included by every user
package stc_pkg;

  typedef enum logic [1:0] {
    STC_CH_IDLE,
    STC_CH_CAPTURE,
    STC_CH_COMPARE
  } stc_ch_mode_t;

  typedef enum logic [1:0] {
    STC_EDGE_NONE,
    STC_EDGE_RISE,
    STC_EDGE_FALL,
    STC_EDGE_ANY
  } stc_edge_t;

endpackage
